/* File: src/egc_defines.svh */
// Purpose: constants for the external input gating block
// Assumes: 10 MHz mclk
// Notes: byte offsets of the APB registers and timing figures
`ifndef EGC_DEFINES_SVH
`define EGC_DEFINES_SVH
`define EGC_CLK_HZ 10000000
`define EGC_NOTICE_MIN 5
`define EGC_DEB_US 10000
`define EGC_OFF_CTRL 12'h000
`define EGC_OFF_STAT 12'h004
`define EGC_OFF_ZONE 12'h008
`define EGC_OFF_TANK 12'h00C
`define EGC_OFF_CAP 12'h010
`define EGC_OFF_OUT 12'h014
`define EGC_OFF_ACT 12'h018
`define EGC_CAP_MIN 8'h32
`define EGC_CAP_MAX 8'h96
`define EGC_CAP_RST 8'h64
`define EGC_GRID_NORM 2'h0
`define EGC_GRID_STOP 2'h1
`define EGC_GRID_CAP1 2'h2
`define EGC_GRID_CAP2 2'h3
`define EGC_CTRL_RST 32'h0000_0000
`define EGC_TEMP_RST 8'h23
`define EGC_TMAX_RST 8'h41
`define EGC_STABLE_RST 4'h1
`endif

/* File: src/egc_pkg.sv */
// Purpose: types for the external input gating block
// Assumes: egc_defines.svh constants
// Notes: register image and whole-module state
package egc_pkg;
    typedef enum logic [2:0] {
        MODE_STOP, MODE_HEAT, MODE_COOL, MODE_TANK,
        MODE_HEAT_TANK, MODE_COOL_TANK, MODE_PUMPDOWN, MODE_FORCE
    } egc_mode_t;

    typedef struct packed {
        logic [7:0] zone1Tgt;
        logic [7:0] zone2Tgt;
        logic [7:0] zoneMax;
        logic [7:0] bufTgt;
    } egc_zone_t;

    typedef struct packed {
        logic [7:0] heat1;
        logic [7:0] hw1;
        logic [7:0] heat2;
        logic [7:0] hw2;
    } egc_cap_t;

    typedef struct packed {
        logic extSwSel;
        logic cmpSwSel;
        logic coolEn;
        logic extBoard;
        logic zone1Pool;
        logic hcUse;
        logic gridEn;
        logic bufferSel;
        logic panelReq;
        logic remoteAct;
        egc_mode_t reqMode;
    } egc_ctrl_t;

    typedef struct packed {
        logic runEn;
        logic heatPumpEn;
        logic waterPumpEn;
        logic heaterEn;
        logic valveOpen;
        logic stopNotice;
        logic powerLed;
        logic hcActive;
        logic weeklyTimerEn;
        egc_mode_t runMode;
    } egc_out_t;

    typedef struct packed {
        egc_ctrl_t ctrl;
        egc_zone_t zone;
        logic [7:0] tankTgt;
        logic [7:0] tankMax;
        egc_cap_t cap;
        logic [3:0] syn1;
        logic [3:0] syn2;
        logic [3:0] stable;
        logic [19:0] debCnt;
        logic [31:0] idleCnt;
        logic [1:0] lastGrid;
        logic [31:0] rdata;
        logic [31:0] effTgt;
        egc_out_t out;
    } egc_state_t;
endpackage

/* File: src/egc_gating.sv */
// Purpose: gates heat pump operation from external contacts and grid code
// Assumes: contacts synchronous inputs, APB register access
// Notes: capacity scaled targets are computed, base targets kept
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "egc_defines.svh"

// Overview of operation
// - Valve opens in heat, closes in cool
// - Valve closed in stop or pump-down
// - Valve open in force mode
// - External switch and panel both on to run
// - Power indicator follows latest panel request only
// - Switch off stops all, raises notice
// - Notice reshown after five idle minutes
// - Switch on clears notice, resumes stored request
// - Config pin picks heat-source or heater mode
// - Heat-source mode needs selection and pin off
// - Heat-source off kills pump, heaters, no notice
// - Heater mode off blocks heaters only
// - Heat/cool switch needs cool, board, not pool
// - Contact open heat modes, closed cool modes
// - Contact flips heat/cool; tank unaffected
// - Weekly timer ignored while heat/cool active
// - Grid only when enabled; capacity 50-150
// - Code 00 normal, targets revert
// - Code 01 inhibits pump and heaters
// - Buffer tank target scaled, zones unchanged
// - No buffer: zones scaled, capped at maximum
// - Tank set point scaled, capped at limit
module egc_gating import egc_pkg::*; #(
    parameter int NOTICE_MIN = `EGC_NOTICE_MIN,
    parameter int DEB_US = `EGC_DEB_US,
    parameter int CLK_HZ = `EGC_CLK_HZ
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic extOnOffContact,
    input wire logic extCmpContact,
    input wire logic cfgPin3,
    input wire logic hcContact,
    input wire logic [1:0] gridSignalInput,
    output logic heatPumpEn,
    output logic waterPumpEn,
    output logic heaterEn,
    output logic valveOpen,
    output logic stopNotice,
    output logic powerLed,
    output logic [2:0] runMode,
    output logic [7:0] zone1Eff,
    output logic [7:0] zone2Eff,
    output logic [7:0] bufEff,
    output logic [7:0] tankEff
);
    localparam longint NOTICE_CYC = longint'(NOTICE_MIN) * 60 * CLK_HZ;
    localparam longint DEB_CYC = longint'(DEB_US) * CLK_HZ / 1000000;
    localparam logic [31:0] NOTICE_LIM = 32'(NOTICE_CYC);
    localparam logic [19:0] DEB_LIM = 20'(DEB_CYC);

    if (DEB_CYC < 1 || DEB_CYC > 1000000 || NOTICE_CYC < 1 ||
        NOTICE_CYC > 64'h0000_0000_FFFF_FFFF) begin : g_bad_timing
        $error("egc_gating: timing parameters out of range");
    end

    egc_state_t cur_ff;
    egc_state_t nxt_cur;

    // ****************************************
    // Scaling helper
    // ****************************************
    function automatic logic [7:0] scaleTemp(input logic [7:0] base,
        input logic [7:0] pct, input logic [7:0] lim);
        logic [15:0] prod;
        logic [15:0] quo;
        prod = base * pct;
        quo = prod / 16'h0064;
        if (quo > {8'h00, lim}) begin
            scaleTemp = lim;
        end else begin
            scaleTemp = quo[7:0];
        end
    endfunction

    function automatic logic [7:0] clampCap(input logic [7:0] v);
        if (v < `EGC_CAP_MIN) begin
            clampCap = `EGC_CAP_MIN;
        end else if (v > `EGC_CAP_MAX) begin
            clampCap = `EGC_CAP_MAX;
        end else begin
            clampCap = v;
        end
    endfunction

    logic [3:0] rawIn;
    assign rawIn = {gridSignalInput, hcContact, extCmpContact};

    logic [3:0] raw2;
    always_comb begin
        raw2 = cur_ff.syn2;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic apbWr;
        logic apbRd;
        logic extOn;
        logic cmpOn;
        logic hcClosed;
        logic [1:0] grid;
        logic hcOk;
        logic srcMode;
        logic htrMode;
        logic gridOn;
        logic [7:0] hcap;
        logic [7:0] wcap;
        egc_mode_t mode;
        logic [7:0] effZ1;
        logic [7:0] effZ2;
        logic [7:0] effBuf;
        logic [7:0] effTank;
        apbWr = 1'b0;
        apbRd = 1'b0;
        extOn = 1'b0;
        cmpOn = 1'b0;
        hcClosed = 1'b0;
        grid = 2'h0;
        hcOk = 1'b0;
        srcMode = 1'b0;
        htrMode = 1'b0;
        gridOn = 1'b0;
        hcap = 8'h00;
        wcap = 8'h00;
        mode = MODE_STOP;
        effZ1 = 8'h00;
        effZ2 = 8'h00;
        effBuf = 8'h00;
        effTank = 8'h00;
        nxt_cur = cur_ff;
        nxt_cur.ctrl.remoteAct = 1'b0;
        // Two-flop sync then stable-count debounce
        nxt_cur.syn1 = rawIn;
        nxt_cur.syn2 = cur_ff.syn1;
        if (raw2 == cur_ff.stable) begin
            nxt_cur.debCnt = 20'h00000;
        end else if (cur_ff.debCnt >= DEB_LIM - 20'h00001) begin
            nxt_cur.stable = raw2;
            nxt_cur.debCnt = 20'h00000;
        end else begin
            nxt_cur.debCnt = cur_ff.debCnt + 20'h00001;
        end
        cmpOn = cur_ff.stable[0];
        hcClosed = cur_ff.stable[1];
        grid = cur_ff.stable[3:2];

        // APB slave, zero wait states
        apbWr = psel && penable && pwrite;
        apbRd = psel && !penable && !pwrite;
        if (apbWr) begin
            case (paddr)
                `EGC_OFF_CTRL: begin
                    nxt_cur.ctrl.extSwSel = pwdata[0];
                    nxt_cur.ctrl.cmpSwSel = pwdata[1];
                    nxt_cur.ctrl.coolEn = pwdata[2];
                    nxt_cur.ctrl.extBoard = pwdata[3];
                    nxt_cur.ctrl.zone1Pool = pwdata[4];
                    nxt_cur.ctrl.hcUse = pwdata[5];
                    nxt_cur.ctrl.gridEn = pwdata[6];
                    nxt_cur.ctrl.bufferSel = pwdata[7];
                    nxt_cur.ctrl.panelReq = pwdata[8];
                    nxt_cur.ctrl.reqMode = egc_mode_t'(pwdata[11:9]);
                    nxt_cur.ctrl.remoteAct = 1'b1;
                end
                `EGC_OFF_ACT: nxt_cur.ctrl.remoteAct = 1'b1;
                `EGC_OFF_ZONE: nxt_cur.zone = pwdata;
                `EGC_OFF_TANK: begin
                    nxt_cur.tankTgt = pwdata[7:0];
                    nxt_cur.tankMax = pwdata[15:8];
                end
                `EGC_OFF_CAP: begin
                    nxt_cur.cap.heat1 = clampCap(pwdata[31:24]);
                    nxt_cur.cap.hw1 = clampCap(pwdata[23:16]);
                    nxt_cur.cap.heat2 = clampCap(pwdata[15:8]);
                    nxt_cur.cap.hw2 = clampCap(pwdata[7:0]);
                end
                default: ;
            endcase
        end
        if (apbRd) begin
            case (paddr)
                `EGC_OFF_CTRL: nxt_cur.rdata = {20'h00000,
                    cur_ff.ctrl.reqMode, cur_ff.ctrl.panelReq,
                    cur_ff.ctrl.bufferSel, cur_ff.ctrl.gridEn,
                    cur_ff.ctrl.hcUse, cur_ff.ctrl.zone1Pool,
                    cur_ff.ctrl.extBoard, cur_ff.ctrl.coolEn,
                    cur_ff.ctrl.cmpSwSel, cur_ff.ctrl.extSwSel};
                `EGC_OFF_STAT: nxt_cur.rdata = {18'h00000,
                    cur_ff.stable, cur_ff.out.runMode,
                    cur_ff.out.weeklyTimerEn, cur_ff.out.hcActive,
                    cur_ff.out.stopNotice, cur_ff.out.valveOpen,
                    cur_ff.out.heaterEn, cur_ff.out.waterPumpEn,
                    cur_ff.out.heatPumpEn};
                `EGC_OFF_ZONE: nxt_cur.rdata = cur_ff.zone;
                `EGC_OFF_TANK: nxt_cur.rdata = {16'h0000,
                    cur_ff.tankMax, cur_ff.tankTgt};
                `EGC_OFF_CAP: nxt_cur.rdata = cur_ff.cap;
                default: nxt_cur.rdata = 32'h0000_0000;
            endcase
        end

        // External on/off contact gating
        extOn = !cur_ff.ctrl.extSwSel || extOnOffContact;
        nxt_cur.out.runEn = cur_ff.ctrl.panelReq && extOn;
        nxt_cur.out.powerLed = nxt_cur.ctrl.panelReq;

        // Notice: raised on stop, reshown after idle, cleared on resume
        if (!extOn) begin
            if (nxt_cur.ctrl.remoteAct) begin
                nxt_cur.out.stopNotice = 1'b0;
                nxt_cur.idleCnt = 32'h0000_0001;
            end else if (cur_ff.idleCnt != 32'h0000_0000) begin
                if (cur_ff.idleCnt >= NOTICE_LIM) begin
                    nxt_cur.out.stopNotice = 1'b1;
                    nxt_cur.idleCnt = 32'h0000_0000;
                end else begin
                    nxt_cur.idleCnt = cur_ff.idleCnt + 32'h0000_0001;
                end
            end
            // Raise wins over a cancel in the same cycle
            if (cur_ff.out.runEn || (!cur_ff.out.stopNotice &&
                cur_ff.idleCnt == 32'h0000_0000)) begin
                nxt_cur.out.stopNotice = 1'b1;
                nxt_cur.idleCnt = 32'h0000_0000;
            end
        end else begin
            nxt_cur.out.stopNotice = 1'b0;
            nxt_cur.idleCnt = 32'h0000_0000;
        end

        // Heat/cool contact limits and flips the mode
        hcOk = cur_ff.ctrl.coolEn && cur_ff.ctrl.extBoard &&
            !cur_ff.ctrl.zone1Pool;
        nxt_cur.out.hcActive = hcOk && cur_ff.ctrl.hcUse;
        nxt_cur.out.weeklyTimerEn = !nxt_cur.out.hcActive;
        mode = cur_ff.ctrl.reqMode;
        if (nxt_cur.out.hcActive) begin
            case (mode)
                MODE_HEAT, MODE_COOL: mode = hcClosed ? MODE_COOL
                    : MODE_HEAT;
                MODE_HEAT_TANK, MODE_COOL_TANK: mode = hcClosed ?
                    MODE_COOL_TANK : MODE_HEAT_TANK;
                default: ;
            endcase
        end
        if (!nxt_cur.out.runEn) begin
            mode = MODE_STOP;
        end
        nxt_cur.out.runMode = mode;

        // Two-way valve
        case (mode)
            MODE_HEAT, MODE_HEAT_TANK: nxt_cur.out.valveOpen = 1'b1;
            MODE_COOL, MODE_COOL_TANK: nxt_cur.out.valveOpen = 1'b0;
            MODE_STOP, MODE_PUMPDOWN: nxt_cur.out.valveOpen = 1'b0;
            MODE_FORCE: nxt_cur.out.valveOpen = 1'b1;
            default: nxt_cur.out.valveOpen = cur_ff.out.valveOpen;
        endcase

        // Load enables
        srcMode = cur_ff.ctrl.cmpSwSel && !cfgPin3;
        htrMode = cur_ff.ctrl.cmpSwSel && cfgPin3;
        gridOn = cur_ff.ctrl.gridEn;
        nxt_cur.out.heatPumpEn = mode != MODE_STOP;
        nxt_cur.out.waterPumpEn = mode != MODE_STOP;
        nxt_cur.out.heaterEn = mode != MODE_STOP;
        if (srcMode && !cmpOn) begin
            nxt_cur.out.heatPumpEn = 1'b0;
            nxt_cur.out.waterPumpEn = 1'b0;
            nxt_cur.out.heaterEn = 1'b0;
        end
        if (htrMode && !cmpOn) begin
            nxt_cur.out.heaterEn = 1'b0;
        end
        if (gridOn && grid == `EGC_GRID_STOP) begin
            nxt_cur.out.heatPumpEn = 1'b0;
            nxt_cur.out.heaterEn = 1'b0;
        end
        nxt_cur.lastGrid = gridOn ? grid : `EGC_GRID_NORM;
        hcap = (grid == `EGC_GRID_CAP2) ? cur_ff.cap.heat2
            : cur_ff.cap.heat1;
        wcap = (grid == `EGC_GRID_CAP2) ? cur_ff.cap.hw2 : cur_ff.cap.hw1;
        hcap = nxt_cur.lastGrid[1] ? hcap : `EGC_CAP_RST;
        wcap = nxt_cur.lastGrid[1] ? wcap : `EGC_CAP_RST;
        if (cur_ff.ctrl.bufferSel) begin
            effBuf = scaleTemp(cur_ff.zone.bufTgt, hcap, 8'hFF);
            effZ1 = cur_ff.zone.zone1Tgt;
            effZ2 = cur_ff.zone.zone2Tgt;
        end else begin
            effBuf = cur_ff.zone.bufTgt;
            effZ1 = scaleTemp(cur_ff.zone.zone1Tgt, hcap,
                cur_ff.zone.zoneMax);
            effZ2 = scaleTemp(cur_ff.zone.zone2Tgt, hcap,
                cur_ff.zone.zoneMax);
        end
        effTank = scaleTemp(cur_ff.tankTgt, wcap, cur_ff.tankMax);
        nxt_cur.effTgt = {effZ1, effZ2, effBuf, effTank};
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cur_ff <= '0;
            cur_ff.zone.zone1Tgt <= `EGC_TEMP_RST;
            cur_ff.zone.zone2Tgt <= `EGC_TEMP_RST;
            cur_ff.zone.zoneMax <= `EGC_TMAX_RST;
            cur_ff.zone.bufTgt <= `EGC_TEMP_RST;
            cur_ff.tankTgt <= `EGC_TEMP_RST;
            cur_ff.tankMax <= `EGC_TMAX_RST;
            cur_ff.cap <= {4{`EGC_CAP_RST}};
            cur_ff.stable <= `EGC_STABLE_RST;
            cur_ff.effTgt <= {4{`EGC_TEMP_RST}};
            cur_ff.out.weeklyTimerEn <= 1'b1;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign prdata = cur_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign heatPumpEn = cur_ff.out.heatPumpEn;
    assign waterPumpEn = cur_ff.out.waterPumpEn;
    assign heaterEn = cur_ff.out.heaterEn;
    assign valveOpen = cur_ff.out.valveOpen;
    assign stopNotice = cur_ff.out.stopNotice;
    assign powerLed = cur_ff.out.powerLed;
    assign runMode = cur_ff.out.runMode;
    assign zone1Eff = cur_ff.effTgt[31:24];
    assign zone2Eff = cur_ff.effTgt[23:16];
    assign bufEff = cur_ff.effTgt[15:8];
    assign tankEff = cur_ff.effTgt[7:0];
endmodule

/* File: tb/egc_gating_props.sv */
// Purpose: port checks for the gating block
// Assumes: one clock domain, async low reset
// Notes: bound to the design after the module
`timescale 1ns/10ps
module egc_gating_props import egc_pkg::*; #(
    parameter int NOTICE_MIN = 5,
    parameter int DEB_US = 10000,
    parameter int CLK_HZ = 10000000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic extOnOffContact,
    input wire logic heatPumpEn,
    input wire logic waterPumpEn,
    input wire logic heaterEn,
    input wire logic valveOpen,
    input wire logic stopNotice,
    input wire logic powerLed,
    input wire logic [2:0] runMode
);
    // ****************************************
    // Valve, notice and indicator checks
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    a_valve_heat: assert property (
        runMode == MODE_HEAT |-> valveOpen) else $error("valve shut");
    a_valve_cool: assert property (
        runMode == MODE_COOL |-> !valveOpen) else $error("valve open");
    a_valve_stop: assert property (
        runMode == MODE_STOP |-> !valveOpen) else $error("valve open");
    a_valve_pdown: assert property (
        runMode == MODE_PUMPDOWN |-> !valveOpen) else $error("valve open");
    a_valve_force: assert property (
        runMode == MODE_FORCE |-> valveOpen) else $error("valve shut");
    a_notice_quiet: assert property (
        stopNotice [*2] |-> !(heatPumpEn || waterPumpEn || heaterEn))
        else $error("load on under notice");
    a_notice_clear: assert property (
        $rose(extOnOffContact) |-> ##[1:2] !stopNotice)
        else $error("notice kept");
    a_led_hold: assert property (
        $fell(extOnOffContact) && !psel |=> $stable(powerLed))
        else $error("indicator moved");
    c_notice: cover property (stopNotice);
    c_force: cover property (runMode == MODE_FORCE && valveOpen);
    c_resume: cover property ($rose(extOnOffContact));
endmodule

bind egc_gating egc_gating_props #(
    .NOTICE_MIN(NOTICE_MIN),
    .DEB_US(DEB_US),
    .CLK_HZ(CLK_HZ)
) i_egc_gating_props (.*);

/* File: tb/egc_contact_model.sv */
// Purpose: external contacts and grid controller
// Assumes: want is {onoff, cmp, hc, grid}
// Notes: changed bouncing lines chatter before settling
`timescale 1ns/10ps
module egc_contact_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [4:0] want,
    input wire logic [3:0] bounce,
    output logic [4:0] pins
);
    // ****************************************
    // Chatter on changed debounced lines
    // ****************************************
    logic [3:0] cnt_ff;
    logic [4:0] mask_ff;
    logic [4:0] last_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 4'h0;
            mask_ff <= 5'h00;
            last_ff <= 5'h00;
            pins <= 5'h00;
        end else begin
            last_ff <= want;
            if (want != last_ff) begin
                cnt_ff <= bounce;
                mask_ff <= (want ^ last_ff) & 5'h0F;
            end else if (cnt_ff != 4'h0) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
            pins <= want ^ (mask_ff & {5{cnt_ff[0]}});
        end
    end
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench for the gating block
// Assumes: short notice and debounce via parameters
// Notes: mode rows in one loop, then hand cases
`timescale 1ns/10ps
`include "egc_defines.svh"
module testbench import egc_pkg::*; ;
    localparam int NMIN = 1;
    localparam int HZ = 100;
    localparam int DUS = 100000;
    localparam int NCYC = NMIN * 60 * HZ;
    localparam int SET = 4 * (DUS / 1000) * HZ / 1000 + 8;
    typedef struct {
        logic [8:0] f;
        egc_mode_t m;
        logic hc;
        egc_mode_t e;
        logic [1:0] v;
    } egc_row_t;
    egc_row_t rows [13] = '{
        '{9'h104, MODE_STOP, 1'h0, MODE_STOP, 2'h2},
        '{9'h104, MODE_HEAT, 1'h0, MODE_HEAT, 2'h3},
        '{9'h104, MODE_COOL, 1'h0, MODE_COOL, 2'h2},
        '{9'h104, MODE_TANK, 1'h0, MODE_TANK, 2'h0},
        '{9'h104, MODE_HEAT_TANK, 1'h0, MODE_HEAT_TANK, 2'h0},
        '{9'h104, MODE_COOL_TANK, 1'h0, MODE_COOL_TANK, 2'h0},
        '{9'h104, MODE_PUMPDOWN, 1'h0, MODE_PUMPDOWN, 2'h2},
        '{9'h104, MODE_FORCE, 1'h0, MODE_FORCE, 2'h3},
        '{9'h12C, MODE_HEAT, 1'h0, MODE_HEAT, 2'h3},
        '{9'h12C, MODE_HEAT, 1'h1, MODE_COOL, 2'h2},
        '{9'h12C, MODE_TANK, 1'h1, MODE_TANK, 2'h0},
        '{9'h12C, MODE_TANK, 1'h0, MODE_TANK, 2'h0},
        '{9'h13C, MODE_HEAT, 1'h1, MODE_HEAT, 2'h3}
    };
    logic mclk, rst_n, psel, penable, pwrite, cfgPin3;
    logic pready, pslverr, heatPumpEn, waterPumpEn, heaterEn;
    logic valveOpen, stopNotice, powerLed;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, ex;
    logic [2:0] runMode;
    logic [7:0] zone1Eff, zone2Eff, bufEff, tankEff;
    logic [4:0] want, pins;
    logic [3:0] bounce;
    int nErrors, numChecks;

    egc_gating #(.NOTICE_MIN(NMIN), .DEB_US(DUS), .CLK_HZ(HZ)) i_egc_gating (
        .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extOnOffContact(pins[4]),
        .extCmpContact(pins[3]), .cfgPin3(cfgPin3), .hcContact(pins[2]),
        .gridSignalInput(pins[1:0]), .heatPumpEn(heatPumpEn),
        .waterPumpEn(waterPumpEn), .heaterEn(heaterEn),
        .valveOpen(valveOpen), .stopNotice(stopNotice),
        .powerLed(powerLed), .runMode(runMode), .zone1Eff(zone1Eff),
        .zone2Eff(zone2Eff), .bufEff(bufEff), .tankEff(tankEff));
    egc_contact_model i_egc_contact_model (.mclk(mclk), .rst_n(rst_n),
        .want(want), .bounce(bounce), .pins(pins));

    // ****************************************
    // Bus, contact and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
        repeat (3) @(posedge mclk);
    endtask
    task automatic setc(input logic [4:0] w);
        want <= w;
        repeat (SET) @(posedge mclk);
    endtask
    function automatic logic [31:0] cw(input logic [8:0] f,
        input egc_mode_t m);
        return {20'h0, m, f};
    endfunction
    function automatic logic [7:0] sc(input int t, input int p, int m);
        return (t * p / 100 > m) ? m[7:0] : 8'(t * p / 100);
    endfunction
    task automatic complete_run;
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and sequence
    // ****************************************
    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        nErrors++;
        complete_run();
    end
    initial begin
        {rst_n, psel, penable, pwrite, cfgPin3} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        want = 5'h18;
        bounce = 4'h0;
        repeat (2) @(posedge mclk);
        chk({valveOpen, heatPumpEn, stopNotice, runMode}, 0);
        rst_n <= 1'h1;
        apb(1'h0, `EGC_OFF_CAP, 32'h0);
        chk(rd, {4{`EGC_CAP_RST}});
        apb(1'h0, `EGC_OFF_TANK, 32'h0);
        chk(rd, {16'h0, `EGC_TMAX_RST, `EGC_TEMP_RST});
        wr(12'h0FC, 32'hFFFF_FFFF);
        apb(1'h0, 12'h0FC, 32'h0);
        chk(rd, 32'h0);
        chk(pslverr, 1'h0);
        $display("registers done");
        foreach (rows[i]) begin
            wr(`EGC_OFF_CTRL, cw(rows[i].f, rows[i].m));
            setc({2'h3, rows[i].hc, 2'h0});
            chk(runMode, rows[i].e);
            if (rows[i].v[1]) chk(valveOpen, rows[i].v[0]);
            apb(1'h0, `EGC_OFF_STAT, 32'h0);
            chk(rd[6:5], (rows[i].f[5:2] == 4'hB) ? 2'h1 : 2'h2);
            $display("row %0d done", i);
        end
        setc(5'h18);
        wr(`EGC_OFF_CTRL, cw(9'h101, MODE_HEAT));
        chk(heatPumpEn, 1);
        setc(5'h08);
        chk({heatPumpEn, waterPumpEn, heaterEn}, 0);
        chk({stopNotice, powerLed}, 2'h3);
        wr(`EGC_OFF_CTRL, cw(9'h001, MODE_HEAT));
        chk(powerLed, 0);
        wr(`EGC_OFF_CTRL, cw(9'h101, MODE_HEAT));
        wr(`EGC_OFF_ACT, 32'h1);
        chk(stopNotice, 0);
        repeat (NCYC - 40) @(posedge mclk);
        chk(stopNotice, 0);
        repeat (80) @(posedge mclk);
        chk(stopNotice, 1);
        setc(5'h18);
        chk({stopNotice, heatPumpEn}, 2'h1);
        $display("on/off contact done");
        wr(`EGC_OFF_CTRL, cw(9'h102, MODE_HEAT));
        setc(5'h10);
        chk({heatPumpEn, waterPumpEn, heaterEn, stopNotice}, 0);
        cfgPin3 <= 1'h1;
        setc(5'h10);
        chk({heatPumpEn, heaterEn}, 2'h2);
        wr(`EGC_OFF_CTRL, cw(9'h100, MODE_HEAT));
        cfgPin3 <= 1'h0;
        setc(5'h10);
        chk(heatPumpEn, 1);
        $display("compressor contact done");
        wr(`EGC_OFF_ZONE, 32'h281E_3223);
        wr(`EGC_OFF_TANK, 32'h0000_281E);
        wr(`EGC_OFF_CAP, 32'h7878_14C8);
        apb(1'h0, `EGC_OFF_CAP, 32'h0);
        chk(rd, 32'h7878_3296);
        setc(5'h19);
        chk(heatPumpEn, 1);
        wr(`EGC_OFF_CTRL, cw(9'h140, MODE_HEAT));
        chk(heatPumpEn, 0);
        bounce <= 4'h4;
        want <= 5'h1A;
        repeat (6) @(posedge mclk);
        chk(zone1Eff, 8'h28);
        setc(5'h1A);
        ex = {sc(40, 120, 50), sc(30, 120, 50), 8'h23, sc(30, 120, 40)};
        chk({zone1Eff, zone2Eff, bufEff, tankEff}, ex);
        setc(5'h1B);
        ex = {sc(40, 50, 50), sc(30, 50, 50), 8'h23, sc(30, 150, 40)};
        chk({zone1Eff, zone2Eff, bufEff, tankEff}, ex);
        setc(5'h18);
        chk({zone1Eff, zone2Eff, bufEff, tankEff}, 32'h281E_231E);
        wr(`EGC_OFF_CTRL, cw(9'h1C0, MODE_HEAT));
        setc(5'h1A);
        ex = {8'h28, 8'h1E, sc(35, 120, 255), sc(30, 120, 40)};
        chk({zone1Eff, zone2Eff, bufEff, tankEff}, ex);
        $display("grid code done");
        rst_n <= 1'h0;
        repeat (2) @(posedge mclk);
        chk({valveOpen, heatPumpEn, stopNotice, powerLed}, 0);
        chk({zone1Eff, zone2Eff, bufEff, tankEff}, {4{`EGC_TEMP_RST}});
        rst_n <= 1'h1;
        apb(1'h0, `EGC_OFF_CTRL, 32'h0);
        chk(rd, `EGC_CTRL_RST);
        $display("reset done");
        complete_run();
    end
endmodule
